// ---- hw/codec_ctrl_pkg.sv ----
// constants, register map and state type for the codec control block
// assumes a 100 MHz hclk and a 2.048 MHz master clock on a pin
package codec_ctrl_pkg;
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned RESET_MIN_NS = 500;
   localparam int unsigned RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
   // master clock nominal period is about 488 ns; four periods allowed
   localparam int unsigned MCLK_LOSS_NS = 2000;
   localparam int unsigned MCLK_LOSS_CYC = (MCLK_LOSS_NS * CLK_MHZ) / 1000;

   localparam logic [7:0] POWER_CTRL_OFS = 8'h00;
   localparam logic [7:0] TX_GAIN_OFS = 8'h04;
   localparam logic [7:0] RX_GAIN_OFS = 8'h08;
   localparam logic [7:0] FORMAT_OFS = 8'h0C;
   localparam logic [7:0] STATUS_OFS = 8'h10;

   localparam int unsigned PWR_ON_BIT = 0;
   localparam int unsigned PWR_DIFF_EAR_BIT = 1;
   localparam int unsigned PWR_EAR_MUTE_BIT = 3;
   localparam int unsigned PWR_MIC_SIL_BIT = 6;
   localparam int unsigned PWR_ST_MUTE_BIT = 7;
   localparam int unsigned TX_DEEP_BIT = 7;
   localparam int unsigned FMT_COMPAND_BIT = 0;
   localparam int unsigned FMT_ALAW_BIT = 1;

   localparam logic [7:0] POWER_CTRL_RST = 8'h00;
   localparam logic [3:0] TX_CODE_RST = 4'h8;
   localparam logic [7:0] TX_GAIN_RST = 8'h08;
   localparam logic [3:0] RX_CODE_RST = 4'h7;
   localparam logic [7:0] FORMAT_RST = 8'h00;

   localparam logic [3:0] RX_CODE_MAX = 4'hC;
   localparam logic [2:0] TX_STEP_MAX = 3'h5;
   localparam logic [8:0] TX_BASE_TENTHS = 9'h0EB;
   localparam logic [8:0] TX_EXT_TENTHS = 9'h078;
   localparam logic [4:0] TX_STEP_TENTHS = 5'h14;
   localparam logic [4:0] RX_TOP_DB = 5'h06;
   localparam logic [3:0] LINEAR_BITS = 4'hF;
   localparam logic [3:0] COMPAND_BITS = 4'h8;

   typedef enum logic [2:0] {
      ST_OFF = 3'b001,
      ST_ON = 3'b010,
      ST_DRAIN = 3'b100
   } power_state_t;
endpackage

// ---- hw/voice_codec_power_gain_ctrl.sv ----
// power sequencing, earpiece select, format and gain decode of a
// voice codec, with its control registers on an ahb-lite slave
// assumes a single master, single whole-word transfers, and that the
// master clock and pcm word-busy level arrive asynchronously on pins
// What this block does
// - reset loads every control register default
// - all settings writable while powered down
// - power bit 1 picks differential earpiece
// - bit 0 clear powers down, depth by transmit bit 7
// - lost master clock forces power-down, output floats
// - pcm stays powered until current word done
// - transmit bit 7 ignores master clock detection
// - linear 15-bit or companded 8-bit format
// - companded mode selects mu-law or a-law
// - power bit 6 silences microphone input
// - transmit code decodes extended/normal mode, steps
// - transmit code resets to 23.5 dB
// - receive code steps +6 to -6 dB
// - receive code resets to -1 dB
`timescale 1ns/1ps
module voice_codec_power_gain_ctrl #(
   parameter int unsigned MCLK_LOSS_CYCLES = codec_ctrl_pkg::MCLK_LOSS_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic master_clock_pin,
   input wire logic pcm_word_busy_pin,
   output logic device_powered,
   output logic pcm_interface_powered,
   output logic serial_sample_output_oe,
   output logic deep_power_down,
   output logic light_power_down,
   output logic master_clock_lost,
   output logic differential_earpiece_output,
   output logic single_ended_earpiece_output,
   output logic earpiece_mute,
   output logic sidetone_mute,
   output logic microphone_silence,
   output logic companded_mode,
   output logic alaw_mode,
   output logic [3:0] sample_bits,
   output logic transmit_extended_mode,
   output logic [3:0] transmit_gain_code,
   output logic [8:0] transmit_total_gain_tenths,
   output logic [3:0] receive_gain_code,
   output logic signed [4:0] receive_gain_db
);
   import codec_ctrl_pkg::*;

   localparam int unsigned LW = $clog2(MCLK_LOSS_CYCLES + 1);

   if (MCLK_LOSS_CYCLES < 2) begin : g_bad_loss
      $error("master clock loss count must be at least 2");
   end

   // transmit codes with bit 2 and bit 1 both set are not defined
   function automatic logic tx_code_ok(input logic [3:0] c);
      tx_code_ok = (c[2:0] <= TX_STEP_MAX);
   endfunction

   function automatic logic rx_code_ok(input logic [3:0] c);
      rx_code_ok = (c <= RX_CODE_MAX);
   endfunction

   // ahb-lite slave, zero wait states; hsize is not checked, every
   // register is a whole aligned word
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic addr_phase;
   logic [7:0] power_ctrl_q;
   logic [7:0] tx_gain_q;
   logic [3:0] rx_code_q;
   logic [7:0] format_q;
   logic [31:0] rdata_q;
   logic [31:0] status_word;
   power_state_t state_q;
   power_state_t state_d;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;
   assign addr_phase = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= addr_phase && hwrite;
         if (addr_phase) begin
            wr_addr_q <= haddr[7:0];
         end
      end
   end

   // read data is sampled in the address phase; the master never
   // overlaps a read address with a write data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         unique case (haddr[7:0])
            POWER_CTRL_OFS: rdata_q <= {24'h00_0000, power_ctrl_q};
            TX_GAIN_OFS: rdata_q <= {24'h00_0000, tx_gain_q};
            RX_GAIN_OFS: rdata_q <= {28'h000_0000, rx_code_q};
            FORMAT_OFS: rdata_q <= {24'h00_0000, format_q};
            STATUS_OFS: rdata_q <= status_word;
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // registers accept writes in any power state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         power_ctrl_q <= POWER_CTRL_RST;
      end else if (wr_pend_q && wr_addr_q == POWER_CTRL_OFS) begin
         power_ctrl_q <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_gain_q <= TX_GAIN_RST;
      end else if (wr_pend_q && wr_addr_q == TX_GAIN_OFS) begin
         tx_gain_q[TX_DEEP_BIT] <= hwdata[TX_DEEP_BIT];
         if (tx_code_ok(hwdata[3:0])) begin
            tx_gain_q[3:0] <= hwdata[3:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_code_q <= RX_CODE_RST;
      end else if (wr_pend_q && wr_addr_q == RX_GAIN_OFS) begin
         if (rx_code_ok(hwdata[3:0])) begin
            rx_code_q <= hwdata[3:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         format_q <= FORMAT_RST;
      end else if (wr_pend_q && wr_addr_q == FORMAT_OFS) begin
         format_q <= {6'h00, hwdata[FMT_ALAW_BIT], hwdata[FMT_COMPAND_BIT]};
      end
   end

   // pins are asynchronous to hclk: two flops before any logic reads
   // them; the third master clock flop only feeds the edge detector
   logic mclk_s1_q;
   logic mclk_s2_q;
   logic mclk_s3_q;
   logic busy_s1_q;
   logic busy_s2_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mclk_s1_q <= 1'b0;
         mclk_s2_q <= 1'b0;
         mclk_s3_q <= 1'b0;
         busy_s1_q <= 1'b0;
         busy_s2_q <= 1'b0;
      end else begin
         mclk_s1_q <= master_clock_pin;
         mclk_s2_q <= mclk_s1_q;
         mclk_s3_q <= mclk_s2_q;
         busy_s1_q <= pcm_word_busy_pin;
         busy_s2_q <= busy_s1_q;
      end
   end

   // master clock watchdog; the counter stops one short of its limit
   // so it never wraps and lets a dead clock look alive again
   logic [LW-1:0] loss_cnt_q;
   logic clock_lost_q;
   logic mclk_edge;

   assign mclk_edge = mclk_s2_q ^ mclk_s3_q;

   // a clock that stops high or low looks the same: no edge seen
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         loss_cnt_q <= '0;
         clock_lost_q <= 1'b1;
      end else if (mclk_edge) begin
         loss_cnt_q <= '0;
         clock_lost_q <= 1'b0;
      end else if (loss_cnt_q == LW'(MCLK_LOSS_CYCLES - 1)) begin
         clock_lost_q <= 1'b1;
      end else begin
         loss_cnt_q <= loss_cnt_q + LW'(1);
      end
   end

   // power sequencer; draining keeps the pcm side up while a word is
   // still leaving, and a new power-up returns straight to on
   logic want_on;
   logic deep_sel;

   assign deep_sel = tx_gain_q[TX_DEEP_BIT];
   // with the override set, clock loss no longer decides power state
   assign want_on = power_ctrl_q[PWR_ON_BIT] &&
                    (deep_sel || !clock_lost_q);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_OFF: begin
            if (want_on) begin
               state_d = ST_ON;
            end
         end
         ST_ON: begin
            if (!want_on) begin
               state_d = busy_s2_q ? ST_DRAIN : ST_OFF;
            end
         end
         ST_DRAIN: begin
            if (want_on) begin
               state_d = ST_ON;
            end else if (!busy_s2_q) begin
               state_d = ST_OFF;
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= ST_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // outputs follow the next state so they change on the same edge
   // as the state register rather than one edge after it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         device_powered <= 1'b0;
         pcm_interface_powered <= 1'b0;
         serial_sample_output_oe <= 1'b0;
         deep_power_down <= 1'b0;
         light_power_down <= 1'b1;
         master_clock_lost <= 1'b1;
      end else begin
         device_powered <= (state_d == ST_ON);
         pcm_interface_powered <= (state_d != ST_OFF);
         serial_sample_output_oe <= (state_d != ST_OFF);
         deep_power_down <= (state_d == ST_OFF) && deep_sel;
         light_power_down <= (state_d == ST_OFF) && !deep_sel;
         master_clock_lost <= clock_lost_q;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         differential_earpiece_output <= 1'b0;
         single_ended_earpiece_output <= 1'b0;
         earpiece_mute <= 1'b0;
         sidetone_mute <= 1'b0;
         microphone_silence <= 1'b0;
      end else begin
         differential_earpiece_output <= (state_d == ST_ON) &&
            power_ctrl_q[PWR_DIFF_EAR_BIT];
         single_ended_earpiece_output <= (state_d == ST_ON) &&
            !power_ctrl_q[PWR_DIFF_EAR_BIT];
         earpiece_mute <= power_ctrl_q[PWR_EAR_MUTE_BIT];
         sidetone_mute <= power_ctrl_q[PWR_ST_MUTE_BIT];
         microphone_silence <= power_ctrl_q[PWR_MIC_SIL_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         companded_mode <= 1'b0;
         alaw_mode <= 1'b0;
         sample_bits <= LINEAR_BITS;
      end else begin
         companded_mode <= format_q[FMT_COMPAND_BIT];
         alaw_mode <= format_q[FMT_COMPAND_BIT] &&
                      format_q[FMT_ALAW_BIT];
         sample_bits <= format_q[FMT_COMPAND_BIT] ? COMPAND_BITS
                                                  : LINEAR_BITS;
      end
   end

   // gain decode, transmit in tenths of a decibel so the half-decibel
   // base stays exact; receive in signed whole decibels
   logic [8:0] tx_total;
   logic [8:0] tx_step_loss;

   assign tx_step_loss = 9'(tx_gain_q[2:0]) * 9'(TX_STEP_TENTHS);
   assign tx_total = TX_BASE_TENTHS +
                     (tx_gain_q[3] ? 9'h000 : TX_EXT_TENTHS) -
                     tx_step_loss;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         transmit_extended_mode <= 1'b0;
         transmit_gain_code <= TX_CODE_RST;
         transmit_total_gain_tenths <= TX_BASE_TENTHS;
         receive_gain_code <= RX_CODE_RST;
         receive_gain_db <= $signed(RX_TOP_DB) - $signed({1'b0, RX_CODE_RST});
      end else begin
         transmit_extended_mode <= !tx_gain_q[3];
         transmit_gain_code <= tx_gain_q[3:0];
         transmit_total_gain_tenths <= tx_total;
         receive_gain_code <= rx_code_q;
         receive_gain_db <= $signed(RX_TOP_DB) -
                            $signed({1'b0, rx_code_q});
      end
   end

   // read-only status: on, pcm powered, draining, deep off, clock lost,
   // synced busy, then the low byte of the transmit total
   assign status_word = {16'h0000,
                         tx_total[7:0],
                         2'b00,
                         busy_s2_q,
                         clock_lost_q,
                         (state_q == ST_OFF) && deep_sel,
                         state_q == ST_DRAIN,
                         state_q != ST_OFF,
                         state_q == ST_ON};

endmodule // voice_codec_power_gain_ctrl

// ---- sim/mclk_src.sv ----
// master clock source seen by the codec control block
// assumes the bench gates it; it stands still while stopped
`timescale 1ns/1ps
module mclk_src (
   input wire logic run,
   output logic mclk
);
   initial mclk = 1'b0;
   // fast test clock, 100 ns period, so loss detection stays short
   always #50 if (run) mclk = ~mclk;
endmodule // mclk_src

// ---- sim/codec_ctrl_sva_sva.sv ----
// port checker for the codec control block
// assumes hclk and active-low async hresetn as its only domain
`timescale 1ns/1ps
module codec_ctrl_sva (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic pcm_word_busy_pin,
   input wire logic device_powered,
   input wire logic pcm_interface_powered,
   input wire logic serial_sample_output_oe,
   input wire logic deep_power_down,
   input wire logic light_power_down,
   input wire logic differential_earpiece_output,
   input wire logic single_ended_earpiece_output,
   input wire logic companded_mode,
   input wire logic alaw_mode,
   input wire logic [3:0] sample_bits,
   input wire logic transmit_extended_mode,
   input wire logic [3:0] transmit_gain_code,
   input wire logic [8:0] transmit_total_gain_tenths,
   input wire logic [3:0] receive_gain_code,
   input wire logic signed [4:0] receive_gain_db
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   a_ear_one_path: assert property (device_powered ==
      (differential_earpiece_output ^ single_ended_earpiece_output))
      else $error("earpiece path does not match power state");
   a_off_depth: assert property (!pcm_interface_powered ==
      (deep_power_down ^ light_power_down))
      else $error("power-down depth flags inconsistent");
   a_oe_float: assert property (serial_sample_output_oe |->
      pcm_interface_powered) else $error("sample output driven while off");
   // two sync flops and the state decision sit between pin and output
   a_drain_busy: assert property ($fell(pcm_interface_powered) |->
      !$past(pcm_word_busy_pin, 3)) else $error("pcm cut during a word");
   a_fmt_bits: assert property (sample_bits ===
      (companded_mode ? 4'h8 : 4'hF)) else $error("sample width wrong");
   a_alaw_comp: assert property (alaw_mode |-> companded_mode)
      else $error("a-law flagged outside companded mode");
   a_tx_total: assert property (transmit_total_gain_tenths == 9'(9'h0EB
      + (transmit_gain_code[3] ? 9'h000 : 9'h078)
      - 9'(transmit_gain_code[2:0]) * 9'h014)
      && transmit_extended_mode == !transmit_gain_code[3])
      else $error("transmit gain decode wrong");
   a_tx_reserved: assert property (transmit_gain_code[2:1] != 2'b11)
      else $error("reserved transmit code active");
   a_rx_decode: assert property (receive_gain_code <= 4'hC &&
      receive_gain_db == 5'h06 - {1'b0, receive_gain_code})
      else $error("receive gain decode wrong");
endmodule // codec_ctrl_sva

bind voice_codec_power_gain_ctrl codec_ctrl_sva u_codec_ctrl_sva (
   .hclk, .hresetn, .hreadyout, .hresp, .pcm_word_busy_pin,
   .device_powered, .pcm_interface_powered, .serial_sample_output_oe,
   .deep_power_down, .light_power_down, .differential_earpiece_output,
   .single_ended_earpiece_output, .companded_mode, .alaw_mode,
   .sample_bits, .transmit_extended_mode, .transmit_gain_code,
   .transmit_total_gain_tenths, .receive_gain_code, .receive_gain_db);

// ---- sim/tb_top.sv ----
// self-checking bench for the codec control block
// assumes the package offsets and a fast test master clock
`timescale 1ns/1ps
module tb_top;
   import codec_ctrl_pkg::*;
   localparam int unsigned LOSS = 40;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic mclk_run, master_clock_pin, pcm_word_busy_pin;
   logic device_powered, pcm_interface_powered, serial_sample_output_oe;
   logic deep_power_down, light_power_down, master_clock_lost;
   logic differential_earpiece_output, single_ended_earpiece_output;
   logic earpiece_mute, sidetone_mute, microphone_silence;
   logic companded_mode, alaw_mode, transmit_extended_mode;
   logic [3:0] sample_bits, transmit_gain_code, receive_gain_code;
   logic [8:0] transmit_total_gain_tenths;
   logic signed [4:0] receive_gain_db;
   int errors, comparisons;
   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   mclk_src u_mclk_src (.run(mclk_run), .mclk(master_clock_pin));
   voice_codec_power_gain_ctrl #(.MCLK_LOSS_CYCLES(LOSS))
      u_voice_codec_power_gain_ctrl (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
      .hrdata, .master_clock_pin, .pcm_word_busy_pin, .device_powered,
      .pcm_interface_powered, .serial_sample_output_oe, .deep_power_down,
      .light_power_down, .master_clock_lost, .differential_earpiece_output,
      .single_ended_earpiece_output, .earpiece_mute, .sidetone_mute,
      .microphone_silence, .companded_mode, .alaw_mode, .sample_bits,
      .transmit_extended_mode, .transmit_gain_code,
      .transmit_total_gain_tenths, .receive_gain_code, .receive_gain_db);
   task test_done;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 16);
      if (hreadyout !== 1'b1) begin
         errors++;
         test_done;
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= w;
      wait_rdy;
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
      cyc(6);
   endtask
   task t_reset;
      bus(1'b0, POWER_CTRL_OFS, 32'h0); chk(rd, 32'h00);
      bus(1'b0, TX_GAIN_OFS, 32'h0); chk(rd, 32'h08);
      bus(1'b0, RX_GAIN_OFS, 32'h0); chk(rd, 32'h07);
      bus(1'b0, FORMAT_OFS, 32'h0); chk(rd, 32'h00);
      bus(1'b0, 8'h20, 32'h0); chk(rd, 32'h00);
      chk(transmit_total_gain_tenths, 32'h0EB);
      chk(receive_gain_db, 32'hFFFFFFFF);
      chk(light_power_down, 32'h1);
   endtask
   // gains and format programmed while still powered down
   task t_gain_fmt;
      logic [3:0] e;
      e = 4'h8;
      for (int c = 0; c < 16; c++) begin
         bus(1'b1, TX_GAIN_OFS, 32'(c));
         if (c[2:1] != 2'b11) e = 4'(c);
         chk(transmit_gain_code, e);
         chk(transmit_extended_mode, !e[3]);
         chk(transmit_total_gain_tenths, 9'(235 + (e[3] ? 0 : 120) - 20 * e[2:0]));
      end
      for (int c = 0; c < 16; c++) begin
         bus(1'b1, RX_GAIN_OFS, 32'(c));
         if (c <= 12) e = 4'(c);
         chk(receive_gain_code, e);
         chk(32'(receive_gain_db), 32'(6 - int'(e)));
      end
      for (int f = 0; f < 4; f++) begin
         bus(1'b1, FORMAT_OFS, 32'(f));
         chk(sample_bits, f[0] ? 32'h8 : 32'hF);
         chk(companded_mode, f[0]);
         chk(alaw_mode, f[0] & f[1]);
      end
      bus(1'b0, TX_GAIN_OFS, 32'h0); chk(rd, 32'h0D);
      chk(device_powered, 32'h0);
   endtask
   task t_power;
      bus(1'b1, POWER_CTRL_OFS, 32'hCB);
      chk(differential_earpiece_output, 32'h1);
      chk(microphone_silence, 32'h1);
      chk(earpiece_mute, 32'h1);
      chk(sidetone_mute, 32'h1);
      bus(1'b1, POWER_CTRL_OFS, 32'h01);
      chk(single_ended_earpiece_output, 32'h1);
      chk(microphone_silence, 32'h0);
      chk(earpiece_mute, 32'h0);
      chk(sidetone_mute, 32'h0);
      bus(1'b1, TX_GAIN_OFS, 32'h8D);
      bus(1'b1, POWER_CTRL_OFS, 32'h00); chk(deep_power_down, 32'h1);
      bus(1'b1, TX_GAIN_OFS, 32'h0D); chk(light_power_down, 32'h1);
   endtask
   task t_clock_loss;
      bus(1'b1, POWER_CTRL_OFS, 32'h01); chk(device_powered, 32'h1);
      mclk_run <= 1'b0;
      cyc(LOSS + 20);
      chk(master_clock_lost, 32'h1);
      chk({device_powered, serial_sample_output_oe}, 32'h0);
      bus(1'b1, TX_GAIN_OFS, 32'h8D); chk(device_powered, 32'h1);
      mclk_run <= 1'b1;
      bus(1'b1, TX_GAIN_OFS, 32'h0D);
      cyc(LOSS);
      chk(master_clock_lost, 32'h0);
   endtask
   task t_drain;
      @(posedge hclk);
      pcm_word_busy_pin <= 1'b1;
      bus(1'b1, POWER_CTRL_OFS, 32'h00);
      chk({device_powered, pcm_interface_powered}, 32'h1);
      @(posedge hclk);
      pcm_word_busy_pin <= 1'b0;
      cyc(8);
      chk(pcm_interface_powered, 32'h0);
   endtask
   // a reset in mid-run must bring back every default
   task t_rereset;
      bus(1'b1, POWER_CTRL_OFS, 32'hCA);
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (RESET_MIN_CYC) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
   endtask
   initial begin
      #500us;
      errors++;
      test_done;
   end
   initial begin
      {hclk, hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
      {pcm_word_busy_pin, errors, comparisons} = '0;
      hsize = 3'h2;
      mclk_run = 1'b1;
      repeat (RESET_MIN_CYC) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_gain_fmt;
      t_power;
      t_clock_loss;
      t_drain;
      t_rereset;
      test_done;
   end
endmodule // tb_top
